// ---- hdl/read_engine_defs.vh ----
// constants for the multi-line serial read engine
`ifndef READ_ENGINE_DEFS_VH
`define READ_ENGINE_DEFS_VH

// accepted opcodes
`define OPC_FAST_READ 8'h0b
`define OPC_DOUBLE_EDGE_QUICK_READ 8'h0d
`define OPC_TWO_LINE_OUTPUT_READ 8'h3b
`define OPC_TWO_LINE_ADDR_DATA_READ 8'hbb
`define OPC_FOUR_LINE_OUTPUT_READ 8'h6b

// opcode skip mode bytes
`define SKIP_NIBBLE 4'ha
`define SKIP_DDR_BYTE 8'ha5

// address space
`define ADDR_W 20
`define ADDR_TOP 20'hfffff
`define ADDR_ZERO 20'h00000

// phase lengths in bits
`define OPC_BITS 5'h08
`define ADDR_BITS 5'h18
`define MODE_BITS 5'h08
`define BYTE_BITS 4'h8

// lane widths
`define LANES_1 3'h1
`define LANES_2 3'h2
`define LANES_4 3'h4

// output enable masks per lane width
`define OE_1 4'h2
`define OE_2 4'h3
`define OE_4 4'hf

// read data buffer
`define DATA_W 8
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3

`endif

// ---- hdl/read_data_fifo.v ----
// read data buffer with registered head word
`timescale 1ns/1ns
`default_nettype none

module read_data_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter PTR_W = 3
) (
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    input wire flush_i,
    input wire in_valid_i,
    output reg in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);
    localparam [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];

    reg [WIDTH-1:0] store_ff [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr_ff;
    reg [PTR_W-1:0] rd_ptr_ff;
    reg [PTR_W:0] count_ff;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [PTR_W-1:0] nxt_rd_ptr = rd_ptr_ff + {{(PTR_W-1){1'b0}}, pop};
    wire [PTR_W:0] nxt_count = count_ff + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

    always @(posedge clk_i) begin
        if (ce_i && push) begin
            store_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i || (ce_i && flush_i)) begin
            wr_ptr_ff <= {PTR_W{1'b0}};
            rd_ptr_ff <= {PTR_W{1'b0}};
            count_ff <= {(PTR_W+1){1'b0}};
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            wr_ptr_ff <= wr_ptr_ff + {{(PTR_W-1){1'b0}}, push};
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            // ready is held in a flop so the source sees back-pressure without a combinational path
            in_ready_o <= (nxt_count < FULL_CNT);
            out_valid_o <= (nxt_count != {(PTR_W+1){1'b0}});
            // bypass when the word being written becomes the new head
            if (push && (wr_ptr_ff == nxt_rd_ptr)) begin
                out_data_o <= in_data_i;
            end else begin
                out_data_o <= store_ff[nxt_rd_ptr];
            end
        end
    end
endmodule // read_data_fifo

`default_nettype wire

// ---- hdl/multi_io_fast_read_engine.v ----
// multi-line serial read engine, oversampled on the reference clock
`timescale 1ns/1ns
`default_nettype none
`include "read_engine_defs.vh"

// Overview of operation
// [RULE_01] quick read 0x0b takes 3-byte address; runs in single, dual or quad protocol
// [RULE_02] byte address advances by one after every data byte
// [RULE_03] top address wraps to zero and reading continues
// [RULE_04] single-edge mode byte 1010xxxx enters opcode skip mode for next transaction
// [RULE_05] any other mode byte clears opcode skip mode
// [RULE_06] double-edge quick read 0x0d uses both edges, quad protocol only
// [RULE_07] double-edge skip mode entered only by mode byte 0xa5
// [RULE_08] double-edge read refused when clock idles high
// [RULE_09] host keeps chip select low through double-edge dummy cycles
// [RULE_10] dummy cycle count comes from the four-bit latency code field
// [RULE_11] two-line output read takes everything before data on serial input
// [RULE_12] two-line output read drives two bits per clock, msb on io1
// [RULE_13] two-line addr/data read takes opcode on one line, address on two
// [RULE_14] two-line addr/data read drives bit 7 on io1, bit 6 on io0 first
// [RULE_15] four-line output read takes opcode, address, mode serially, then drives four lines
// [RULE_16] four-line output read drives bits 7..4 on io3..io0, then low nibble
// [RULE_17] host sets quad enable before issuing four-line output read
// [RULE_18] only low four bits of top address byte are used
// [RULE_19] reset clears opcode skip mode

module multi_io_fast_read_engine #(
    parameter ADDR_W = `ADDR_W,
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter FIFO_PTR_W = `FIFO_PTR_W
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire ce_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire [3:0] io_i,
    output reg [3:0] io_o,
    output reg [3:0] io_oe_o,
    input wire [3:0] latency_code_field_i,
    input wire quad_enable_i,
    input wire dual_protocol_mode_i,
    input wire quad_protocol_mode_i,
    output reg mem_req_o,
    output reg [ADDR_W-1:0] mem_addr_o,
    input wire [7:0] mem_rdata_i,
    input wire mem_rvalid_i,
    output wire mem_rready_o,
    output reg [ADDR_W-1:0] cur_addr_o,
    output reg opcode_skip_mode_o,
    output reg underrun_o
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_OPC = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_MODE = 3'h3;
    localparam [2:0] ST_DUMMY = 3'h4;
    localparam [2:0] ST_DATA = 3'h5;
    localparam [2:0] ST_IGNORE = 3'h6;

    // pin synchronisers; stage 0 feeds only stage 1
    reg [2:0] sclk_sync_ff;
    reg [2:0] cs_sync_ff;
    reg [3:0] io_s1_ff;
    reg [3:0] io_s2_ff;

    reg [2:0] state_ff;
    reg [4:0] cnt_ff;
    reg [23:0] sh_ff;
    reg [2:0] addr_w_ff;
    reg [2:0] data_w_ff;
    reg ddr_ff;
    reg cpol_ff;
    reg [7:0] out_sh_ff;
    reg [3:0] out_cnt_ff;
    reg first_byte_ff;

    wire fifo_valid;
    wire [7:0] fifo_data;

    wire sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    wire sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    wire cs_low = ~cs_sync_ff[1];
    wire cs_start = ~cs_sync_ff[1] & cs_sync_ff[2];
    wire spi_mode = ~dual_protocol_mode_i & ~quad_protocol_mode_i;

    wire [2:0] proto_w = quad_protocol_mode_i ? `LANES_4 :
                         (dual_protocol_mode_i ? `LANES_2 : `LANES_1);
    wire [2:0] in_w = (state_ff == ST_OPC) ? proto_w : addr_w_ff;
    // opcode always single edge; address and mode also sample on falls in double-edge reads
    wire smp_edge = sclk_rise |
                    (ddr_ff & sclk_fall & ((state_ff == ST_ADDR) | (state_ff == ST_MODE))); // RULE_06
    wire drv_edge = sclk_fall | (ddr_ff & sclk_rise); // RULE_06
    wire [4:0] nxt_cnt = cnt_ff + {2'b00, in_w};
    wire [23:0] nxt_sh = shift_in(sh_ff, io_s2_ff, in_w);
    wire [4:0] nxt_dummy = cnt_ff + 5'h01;
    wire load_byte = cs_low & ~cs_start & (state_ff == ST_DATA) & drv_edge &
                     (out_cnt_ff == 4'h0) & fifo_valid;
    wire mem_take = mem_req_o & mem_rvalid_i & mem_rready_o;

    function [23:0] shift_in;
        input [23:0] sh;
        input [3:0] io;
        input [2:0] w;
        begin
            case (w)
                `LANES_2: shift_in = {sh[21:0], io[1:0]}; // RULE_13
                `LANES_4: shift_in = {sh[19:0], io};
                default: shift_in = {sh[22:0], io[0]}; // RULE_11
            endcase
        end
    endfunction

    // top bits of a byte placed on the lanes of the active width
    function [3:0] lanes;
        input [7:0] b;
        input [2:0] w;
        begin
            case (w)
                `LANES_2: lanes = {2'b00, b[7:6]}; // RULE_12 RULE_14
                `LANES_4: lanes = b[7:4]; // RULE_16
                default: lanes = {2'b00, b[7], 1'b0};
            endcase
        end
    endfunction

    function [3:0] lane_mask;
        input [2:0] w;
        begin
            case (w)
                `LANES_2: lane_mask = `OE_2;
                `LANES_4: lane_mask = `OE_4;
                default: lane_mask = `OE_1;
            endcase
        end
    endfunction

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            sclk_sync_ff <= 3'h0;
            cs_sync_ff <= 3'h7;
            io_s1_ff <= 4'h0;
            io_s2_ff <= 4'h0;
        end else if (ce_i) begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_i};
            cs_sync_ff <= {cs_sync_ff[1:0], cs_n_i};
            io_s1_ff <= io_i;
            io_s2_ff <= io_s1_ff;
        end
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 5'h00;
            sh_ff <= 24'h000000;
            addr_w_ff <= `LANES_1;
            data_w_ff <= `LANES_1;
            ddr_ff <= 1'b0;
            cpol_ff <= 1'b0;
            out_sh_ff <= 8'h00;
            out_cnt_ff <= 4'h0;
            first_byte_ff <= 1'b0;
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
            mem_req_o <= 1'b0;
            mem_addr_o <= `ADDR_ZERO;
            cur_addr_o <= `ADDR_ZERO;
            opcode_skip_mode_o <= 1'b0; // RULE_19
            underrun_o <= 1'b0;
        end else if (ce_i) begin
            // prefetch address runs ahead of the shifter through the buffer
            if (mem_take) begin
                if (mem_addr_o == `ADDR_TOP) begin
                    mem_addr_o <= `ADDR_ZERO; // RULE_03
                end else begin
                    mem_addr_o <= mem_addr_o + 1'b1; // RULE_02
                end
            end
            if (!cs_low) begin
                // a deselect ends any phase; a double-edge read cut in its dummy cycles returns nothing
                state_ff <= ST_IDLE; // RULE_09
                io_oe_o <= 4'h0;
                mem_req_o <= 1'b0;
            end else if (cs_start) begin
                cnt_ff <= 5'h00;
                sh_ff <= 24'h000000;
                cpol_ff <= sclk_sync_ff[1];
                underrun_o <= 1'b0;
                io_oe_o <= 4'h0;
                if (opcode_skip_mode_o) begin
                    state_ff <= ST_ADDR; // RULE_04
                end else begin
                    state_ff <= ST_OPC; // RULE_05
                end
            end else begin
                case (state_ff)
                    ST_OPC: begin
                        if (smp_edge) begin
                            sh_ff <= nxt_sh;
                            cnt_ff <= nxt_cnt;
                            if (nxt_cnt == `OPC_BITS) begin
                                cnt_ff <= 5'h00;
                                ddr_ff <= 1'b0;
                                state_ff <= ST_IGNORE;
                                case (nxt_sh[7:0])
                                    `OPC_FAST_READ: begin
                                        addr_w_ff <= proto_w; // RULE_01
                                        data_w_ff <= proto_w;
                                        state_ff <= ST_ADDR;
                                    end
                                    `OPC_DOUBLE_EDGE_QUICK_READ: begin
                                        if (quad_protocol_mode_i && !cpol_ff) begin // RULE_06 RULE_08
                                            addr_w_ff <= `LANES_4;
                                            data_w_ff <= `LANES_4;
                                            ddr_ff <= 1'b1;
                                            state_ff <= ST_ADDR;
                                        end
                                    end
                                    `OPC_TWO_LINE_OUTPUT_READ: begin
                                        if (spi_mode) begin
                                            addr_w_ff <= `LANES_1; // RULE_11
                                            data_w_ff <= `LANES_2;
                                            state_ff <= ST_ADDR;
                                        end
                                    end
                                    `OPC_TWO_LINE_ADDR_DATA_READ: begin
                                        if (spi_mode) begin
                                            addr_w_ff <= `LANES_2; // RULE_13
                                            data_w_ff <= `LANES_2;
                                            state_ff <= ST_ADDR;
                                        end
                                    end
                                    `OPC_FOUR_LINE_OUTPUT_READ: begin
                                        // refused unless quad enable is set beforehand
                                        if (spi_mode && quad_enable_i) begin // RULE_17
                                            addr_w_ff <= `LANES_1; // RULE_15
                                            data_w_ff <= `LANES_4;
                                            state_ff <= ST_ADDR;
                                        end
                                    end
                                    default: begin
                                        state_ff <= ST_IGNORE;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (smp_edge) begin
                            sh_ff <= nxt_sh;
                            cnt_ff <= nxt_cnt;
                            if (nxt_cnt == `ADDR_BITS) begin
                                cnt_ff <= 5'h00;
                                mem_addr_o <= nxt_sh[ADDR_W-1:0]; // RULE_18
                                cur_addr_o <= nxt_sh[ADDR_W-1:0]; // RULE_18
                                mem_req_o <= 1'b1;
                                state_ff <= ST_MODE;
                            end
                        end
                    end
                    ST_MODE: begin
                        if (smp_edge) begin
                            sh_ff <= nxt_sh;
                            cnt_ff <= nxt_cnt;
                            if (nxt_cnt == `MODE_BITS) begin
                                cnt_ff <= 5'h00;
                                out_cnt_ff <= 4'h0;
                                first_byte_ff <= 1'b1;
                                if (ddr_ff) begin
                                    opcode_skip_mode_o <= (nxt_sh[7:0] == `SKIP_DDR_BYTE); // RULE_07
                                end else begin
                                    opcode_skip_mode_o <= (nxt_sh[7:4] == `SKIP_NIBBLE); // RULE_04 RULE_05
                                end
                                if (latency_code_field_i == 4'h0) begin
                                    state_ff <= ST_DATA;
                                end else begin
                                    state_ff <= ST_DUMMY;
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        // dummy cycles count whole clocks, also in double-edge reads
                        if (sclk_rise) begin
                            cnt_ff <= nxt_dummy;
                            if (nxt_dummy == {1'b0, latency_code_field_i}) begin // RULE_10
                                state_ff <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (drv_edge) begin
                            if (out_cnt_ff == 4'h0) begin
                                if (fifo_valid) begin
                                    io_o <= lanes(fifo_data, data_w_ff);
                                    io_oe_o <= lane_mask(data_w_ff); // RULE_12 RULE_15
                                    out_sh_ff <= fifo_data << data_w_ff;
                                    out_cnt_ff <= `BYTE_BITS - {1'b0, data_w_ff};
                                    first_byte_ff <= 1'b0;
                                    if (!first_byte_ff) begin
                                        if (cur_addr_o == `ADDR_TOP) begin
                                            cur_addr_o <= `ADDR_ZERO; // RULE_03
                                        end else begin
                                            cur_addr_o <= cur_addr_o + 1'b1; // RULE_02
                                        end
                                    end
                                end else begin
                                    // memory too slow: the last level stays on the lanes
                                    underrun_o <= 1'b1;
                                end
                            end else begin
                                io_o <= lanes(out_sh_ff, data_w_ff); // RULE_14 RULE_16
                                out_sh_ff <= out_sh_ff << data_w_ff;
                                out_cnt_ff <= out_cnt_ff - {1'b0, data_w_ff};
                            end
                        end
                    end
                    ST_IGNORE: begin
                        io_oe_o <= 4'h0;
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // buffer is emptied whenever the device is deselected, so stale prefetch never leaks
    read_data_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W)
    ) u_read_data_fifo (
        .clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .flush_i(cs_sync_ff[1]),
        .in_valid_i(mem_rvalid_i & mem_req_o),
        .in_ready_o(mem_rready_o),
        .in_data_i(mem_rdata_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(load_byte),
        .out_data_o(fifo_data)
    );
endmodule // multi_io_fast_read_engine

`default_nettype wire

// ---- tb/multi_io_fast_read_engine_props.sv ----
// assertion checker for the multi-line read engine
`timescale 1ns/1ns
`default_nettype none
module read_engine_props #(
    parameter ADDR_W = 20
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_oe_o,
    input wire logic mem_req_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire logic mem_rready_o,
    input wire logic opcode_skip_mode_o,
    input wire logic underrun_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    wire logic take = mem_req_o && mem_rvalid_i && mem_rready_o;
    reset_clear_a: assert property (disable iff (1'b0) reset_i |=> !opcode_skip_mode_o && !mem_req_o)
        else $error("reset left state set");
    lane_set_a: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("illegal lane enable set");
    lane_turn_a: assert property ($changed(io_oe_o) |-> io_oe_o == 4'h0 || $past(io_oe_o) == 4'h0)
        else $error("lanes switched mid transfer");
    lane_window_a: assert property (io_oe_o != 4'h0 |-> !$past(cs_n_i, 6))
        else $error("lanes driven while deselected");
    addr_step_a: assert property (take |=> !mem_req_o || mem_addr_o == $past(mem_addr_o) + 1'b1)
        else $error("fetch address did not step by one");
    addr_hold_a: assert property (mem_req_o && !take |=> !mem_req_o || $stable(mem_addr_o))
        else $error("fetch address moved without a take");
    req_window_a: assert property (mem_req_o |-> !$past(cs_n_i, 6))
        else $error("fetch request while deselected");
    skip_change_a: assert property ($changed(opcode_skip_mode_o) && !$past(reset_i) |-> !$past(cs_n_i))
        else $error("skip mode changed outside a transaction");
    underrun_hold_a: assert property (underrun_o && cs_n_i |=> underrun_o)
        else $error("underrun flag dropped while deselected");
    skip_seen_c: cover property ($rose(opcode_skip_mode_o));
endmodule // read_engine_props

bind multi_io_fast_read_engine read_engine_props #(.ADDR_W(ADDR_W)) u_props (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_rvalid_i(mem_rvalid_i), .mem_rready_o(mem_rready_o),
    .opcode_skip_mode_o(opcode_skip_mode_o), .underrun_o(underrun_o));
`default_nettype wire

// ---- tb/spi_host_model.sv ----
// behavioural host controller driving the serial read link
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input wire logic ref_clk_i,
    input wire logic [3:0] line_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] io_o,
    output logic [3:0] oe_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        io_o = 4'h0;
        oe_o = 4'h0;
    end
    // clock level at the select fall picks the link mode
    task start(input logic idle_hi);
        begin
            @(posedge ref_clk_i);
            sclk_o <= idle_hi;
            repeat (3) @(posedge ref_clk_i);
            cs_n_o <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask
    // sample late in the low phase: the device answers some cycles after the fall
    task clk(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
        begin
            @(posedge ref_clk_i);
            sclk_o <= 1'b0;
            io_o <= d;
            oe_o <= oe;
            repeat (6) @(posedge ref_clk_i);
            q = line_i;
            sclk_o <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
    task send(input logic [31:0] v, input integer n, input integer ln);
        integer i;
        logic [3:0] q;
        begin
            for (i = n - ln; i >= 0; i = i - ln) begin
                clk(4'((v >> i) & ((1 << ln) - 1)), 4'((1 << ln) - 1), q);
            end
        end
    endtask
    task recv(input integer ln, output logic [7:0] b);
        integer i;
        logic [3:0] q;
        begin
            b = 8'h00;
            for (i = 0; i < 8; i = i + ln) begin
                clk(4'h0, 4'h0, q);
                b = (b << ln) | (ln == 1 ? {7'h00, q[1]} : {4'h0, q & 4'((1 << ln) - 1)});
            end
        end
    endtask
    task stop;
        begin
            @(posedge ref_clk_i);
            sclk_o <= 1'b0;
            oe_o <= 4'h0;
            repeat (5) @(posedge ref_clk_i);
            cs_n_o <= 1'b1;
            repeat (12) @(posedge ref_clk_i);
        end
    endtask
endmodule // spi_host_model
`default_nettype wire

// ---- tb/tb_multi_io_fast_read_engine.sv ----
// self-checking bench for the multi-line read engine
`timescale 1ns/1ns
`default_nettype none
`include "read_engine_defs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_multi_io_fast_read_engine;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] lat = 4'h1;
    logic qen = 1'b0;
    logic dpm = 1'b0;
    logic qpm = 1'b0;
    logic stall = 1'b0;
    logic saw_full = 1'b0;
    integer fail_count = 0;
    integer checked = 0;
    wire cs_n, sclk, mem_req, rready, skip, under;
    wire [3:0] h_io, h_oe, d_io, d_oe, line;
    wire [19:0] mem_addr, cur_addr;
    function automatic logic [7:0] mem_f(input logic [19:0] a);
        mem_f = a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]} ^ 8'h5a;
    endfunction
    // a lane nobody drives shows the inverse of the host's last level
    assign line = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & ~h_io);
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (mem_req && !rready) saw_full <= 1'b1;
    spi_host_model u_host (.ref_clk_i(ref_clk_i), .line_i(line), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(h_io),
        .oe_o(h_oe));
    multi_io_fast_read_engine u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1), .cs_n_i(cs_n),
        .sclk_i(sclk), .io_i(line), .io_o(d_io), .io_oe_o(d_oe), .latency_code_field_i(lat), .quad_enable_i(qen),
        .dual_protocol_mode_i(dpm), .quad_protocol_mode_i(qpm), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
        .mem_rdata_i(mem_f(mem_addr)), .mem_rvalid_i(mem_req & ~stall), .mem_rready_o(rready),
        .cur_addr_o(cur_addr), .opcode_skip_mode_o(skip), .underrun_o(under));
    task hdr(input logic [7:0] opc, input integer cl, input logic [23:0] a, input logic [7:0] md, input integer al);
        begin
            u_host.start(1'b0);
            if (cl != 0) u_host.send({24'h0, opc}, 8, cl);
            u_host.send({8'h0, a}, 24, al);
            u_host.send({24'h0, md}, 8, al);
            u_host.send(32'h0, lat * al, al);
        end
    endtask
    task rd(input logic [7:0] opc, input integer cl, input logic [23:0] a, input logic [7:0] md,
            input integer al, input integer dl, input integer nb);
        integer k;
        logic [7:0] b;
        logic [19:0] x;
        begin
            hdr(opc, cl, a, md, al);
            for (k = 0; k < nb; k++) begin
                x = a[19:0] + k[19:0];
                u_host.recv(dl, b);
                `CHK(b, mem_f(x))
                `CHK(cur_addr, x)
            end
            `CHK(d_oe, dl == 1 ? 4'h2 : dl == 2 ? 4'h3 : 4'hf)
            u_host.stop;
            `CHK(d_oe, 4'h0)
        end
    endtask
    // refused commands carry a skip-enabling mode byte on the lanes an accepted command would use,
    // so acceptance would show; on the double-edge sampling each address nibble is taken twice, so the mode byte reads aa
    task refuse(input logic [7:0] opc, input integer cl, input logic idle_hi, input integer al);
        logic [7:0] b;
        logic old;
        begin
            old = skip;
            u_host.start(idle_hi);
            u_host.send({24'h0, opc}, 8, cl);
            u_host.send(32'h00123a56, 24, al);
            u_host.send(32'h000000a5, 8, al);
            u_host.recv(cl, b);
            `CHK(d_oe, 4'h0)
            u_host.stop;
            `CHK(skip, old)
        end
    endtask
    task t_single;
        begin
            lat <= 4'h1;
            rd(`OPC_FAST_READ, 1, 24'haffffe, 8'ha3, 1, 1, 4);
            `CHK(skip, 1'b1)
            `CHK(saw_full, 1'b1)
        end
    endtask
    task t_skip;
        begin
            lat <= 4'h3;
            rd(8'h00, 0, 24'h000123, 8'h5a, 1, 1, 2);
            `CHK(skip, 1'b0)
            rd(`OPC_FAST_READ, 1, 24'h0fff00, 8'hb0, 1, 1, 1);
            `CHK(skip, 1'b0)
        end
    endtask
    task t_lanes;
        begin
            lat <= 4'h0;
            rd(`OPC_TWO_LINE_OUTPUT_READ, 1, 24'h012345, 8'h00, 1, 2, 3);
            rd(`OPC_TWO_LINE_ADDR_DATA_READ, 1, 24'h054321, 8'h00, 2, 2, 3);
            dpm <= 1'b1;
            lat <= 4'h2;
            rd(`OPC_FAST_READ, 2, 24'h0abcde, 8'h00, 2, 2, 2);
            refuse(`OPC_TWO_LINE_OUTPUT_READ, 2, 1'b0, 1);
            qpm <= 1'b1;
            rd(`OPC_FAST_READ, 4, 24'h07777f, 8'h00, 4, 4, 2);
            refuse(`OPC_DOUBLE_EDGE_QUICK_READ, 4, 1'b1, 4);
            dpm <= 1'b0;
            qpm <= 1'b0;
            refuse(`OPC_DOUBLE_EDGE_QUICK_READ, 1, 1'b0, 4);
        end
    endtask
    task t_quad;
        begin
            lat <= 4'h1;
            refuse(`OPC_FOUR_LINE_OUTPUT_READ, 1, 1'b0, 1);
            qen <= 1'b1;
            rd(`OPC_FOUR_LINE_OUTPUT_READ, 1, 24'h0fffff, 8'h00, 1, 4, 3);
        end
    endtask
    // memory stalls from the start, so the buffer is empty when data must begin
    task t_buffer;
        logic [7:0] b;
        begin
            stall <= 1'b1;
            hdr(`OPC_FAST_READ, 1, 24'h000040, 8'h00, 1);
            u_host.recv(1, b);
            `CHK(under, 1'b1)
            stall <= 1'b0;
            u_host.stop;
        end
    endtask
    task t_reset;
        begin
            rd(`OPC_FAST_READ, 1, 24'h000300, 8'ha0, 1, 1, 1);
            `CHK(skip, 1'b1)
            @(posedge ref_clk_i) reset_i <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            reset_i <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            `CHK(skip, 1'b0)
            rd(`OPC_FAST_READ, 1, 24'h000310, 8'h00, 1, 1, 1);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        t_single;
        t_skip;
        t_lanes;
        t_quad;
        t_buffer;
        t_reset;
        end_sim;
    end
    // whole run is near 7k cycles; this allows a wide margin
    initial begin
        #400000;
        fail_count++;
        end_sim;
    end
endmodule // tb_multi_io_fast_read_engine
`default_nettype wire
